//--- verilog/tsq_regs.svh
`ifndef TSQ_REGS_SVH
`define TSQ_REGS_SVH

// ----------------------------------------
// register byte addresses (word aligned)
// ----------------------------------------
`define TSQ_ADDR_CTRL 8'h00
`define TSQ_ADDR_CMD 8'h04
`define TSQ_ADDR_DELAY 8'h08
`define TSQ_ADDR_OPCOND 8'h0C
`define TSQ_ADDR_IRQ_STAT 8'h10
`define TSQ_ADDR_IRQ_MASK 8'h14
`define TSQ_ADDR_STATE 8'h18

// ----------------------------------------
// control register fields
// ----------------------------------------
`define TSQ_CTRL_CONT_BIT 0
`define TSQ_CTRL_SRC_LSB 4
`define TSQ_CTRL_SRC_MSB 5

// ----------------------------------------
// command register bits (write one to issue)
// ----------------------------------------
`define TSQ_CMD_ARM_BIT 0
`define TSQ_CMD_ABORT_BIT 1
`define TSQ_CMD_RST_BIT 2
`define TSQ_CMD_BUS_TRIG_BIT 3
`define TSQ_CMD_BYPASS_BIT 4

// ----------------------------------------
// operation condition bits
// ----------------------------------------
`define TSQ_OPC_MEAS_BIT 4
`define TSQ_OPC_WAIT_BIT 5

// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define TSQ_IRQ_TRIG_BIT 0
`define TSQ_IRQ_START_BIT 1
`define TSQ_IRQ_DONE_BIT 2
`define TSQ_IRQ_IDLE_BIT 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define TSQ_RST_DELAY 32'h0000_0000
`define TSQ_RST_SRC 2'h0
`define TSQ_RST_MASK 4'h0

`endif

//--- verilog/tsq_pkg.sv
package tsq_pkg;

  // trigger source select
  typedef enum logic [1:0] {
    TSQ_SRC_BUS = 2'h0,
    TSQ_SRC_INT = 2'h1,
    TSQ_SRC_EXT = 2'h2
  } tsq_src_t;

  // sequencer states, gray coded along idle-init-detect-delay-seq
  typedef enum logic [2:0] {
    TSQ_IDLE = 3'b000,
    TSQ_INIT = 3'b001,
    TSQ_DETECT = 3'b011,
    TSQ_DELAY = 3'b010,
    TSQ_SEQ = 3'b110
  } tsq_state_t;

endpackage : tsq_pkg

//--- verilog/tsq_ext_sync.sv
`timescale 1ns/1ps
// ----------------------------------------
// external trigger synchroniser and edge detector
// ----------------------------------------
module tsq_ext_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_trig_i,
  output logic rise_o
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } tsq_sync_st_t;

  tsq_sync_st_t s_ff;
  tsq_sync_st_t nxt_s;

  // first stage only feeds the second; edge taken from later stages
  always_comb begin
    nxt_s = s_ff;
    nxt_s.meta = ext_trig_i;
    nxt_s.sync = s_ff.meta;
    nxt_s.last = s_ff.sync;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rise_o = s_ff.sync & ~s_ff.last;

endmodule : tsq_ext_sync

//--- verilog/tsq_top.sv
`timescale 1ns/1ps
`include "tsq_regs.svh"
module tsq_top import tsq_pkg::*; #(
  parameter int DELAY_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ext_trig_i,
  input wire logic int_trig_i,
  input wire logic meas_done_i,
  output logic meas_start_o,
  output logic [15:0] op_cond_o,
  output logic irq_o
);

  // ----------------------------------------
  // sequencer state and helpers
  // ----------------------------------------
  // every flip-flop of the block except the trigger synchroniser lives in this one struct; the condition word
  // and the read word are registered here too, so no output is combinational
  // except waitrequest, which must answer within the cycle, and irq, the masked OR of two registers
  typedef struct packed {
    tsq_state_t state;
    logic cont;
    logic [1:0] src;
    logic [DELAY_W-1:0] delay;
    logic [DELAY_W-1:0] dcnt;
    logic bypass_pend;
    logic start;
    logic ack;
    logic [31:0] rdata;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [15:0] opc; // operation condition word
  } tsq_st_t;

  tsq_st_t s_ff;
  tsq_st_t nxt_s;
  logic ext_rise;
  logic wr_ok;
  logic rd_ok;
  logic [4:0] cmd;
  logic trig_evt;
  logic [3:0] irq_set;

  // ----------------------------------------
  // external trigger front end
  // ----------------------------------------
  tsq_ext_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ext_trig_i(ext_trig_i),
    .rise_o(ext_rise)
  );

  // byte-lane merge, used for the delay register
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_be

  // ----------------------------------------
  // bus handshake: one wait cycle, then acknowledge
  // ----------------------------------------
  // the wait cycle is used to capture the read word, so read data stands at
  // the edge where waitrequest is seen low; every access therefore costs two
  // cycles, traded for a registered read path
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s_ff.ack;
  assign wr_ok = avs_write_i & s_ff.ack;
  assign rd_ok = avs_read_i & s_ff.ack;
  assign cmd = (wr_ok && avs_address_i == `TSQ_ADDR_CMD && avs_byteenable_i[0]) ?
               avs_writedata_i[4:0] : 5'h00;

  // selected trigger source; bus needs nothing more than the command
  always_comb begin
    case (tsq_src_t'(s_ff.src))
      TSQ_SRC_BUS: trig_evt = cmd[`TSQ_CMD_BUS_TRIG_BIT];
      TSQ_SRC_INT: trig_evt = int_trig_i;
      TSQ_SRC_EXT: trig_evt = ext_rise;
      default: trig_evt = 1'b0;
    endcase
  end

  // ----------------------------------------
  // operation condition decode
  // ----------------------------------------
  // condition bits depend on the state alone; they are registered together
  // with the state so the word changes in the same cycle as the sequencer
  function automatic logic [15:0] cond_of(input tsq_state_t st);
    logic [15:0] c;
    c = 16'h0000;
    c[`TSQ_OPC_WAIT_BIT] = (st == TSQ_DETECT);
    c[`TSQ_OPC_MEAS_BIT] = (st == TSQ_SEQ);
    return c;
  endfunction : cond_of

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // unmapped offsets read as zero; the state word is a debug view only
  function automatic logic [31:0] read_word(input tsq_st_t st, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `TSQ_ADDR_CTRL: w = {26'h0, st.src, 3'h0, st.cont};
      `TSQ_ADDR_DELAY: w = 32'(st.delay);
      `TSQ_ADDR_OPCOND: w = {16'h0, st.opc};
      `TSQ_ADDR_IRQ_STAT: w = {28'h0, st.irq_stat};
      `TSQ_ADDR_IRQ_MASK: w = {28'h0, st.irq_mask};
      `TSQ_ADDR_STATE: w = {28'h0, st.bypass_pend, st.state};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.start = 1'b0;
    nxt_s.ack = (avs_read_i | avs_write_i) & ~s_ff.ack;
    irq_set = 4'h0;

    // register writes; a delay rewritten while counting only applies to the
    // next trigger, because the down-counter is loaded at detection
    if (wr_ok) begin
      case (avs_address_i)
        `TSQ_ADDR_CTRL: begin
          if (avs_byteenable_i[0]) begin
            nxt_s.cont = avs_writedata_i[`TSQ_CTRL_CONT_BIT];
            nxt_s.src = avs_writedata_i[`TSQ_CTRL_SRC_MSB:`TSQ_CTRL_SRC_LSB];
          end
        end
        `TSQ_ADDR_DELAY: nxt_s.delay = DELAY_W'(merge_be(32'(s_ff.delay), avs_writedata_i,
                                                         avs_byteenable_i));
        `TSQ_ADDR_IRQ_MASK: begin
          if (avs_byteenable_i[0]) begin
            nxt_s.irq_mask = avs_writedata_i[3:0];
          end
        end
        default: ;
      endcase
    end

    // bypass is latched and used once by the next detection pass
    if (cmd[`TSQ_CMD_BYPASS_BIT]) begin
      nxt_s.bypass_pend = 1'b1;
    end

    // sequencer: downward path idle, initiate, detection, delay, sequence;
    // the upward path from sequence goes straight back to detection or idle
    case (s_ff.state)
      TSQ_IDLE: begin
        if (cmd[`TSQ_CMD_ARM_BIT] || s_ff.cont) begin
          nxt_s.state = TSQ_INIT;
        end
      end
      TSQ_INIT: begin
        nxt_s.state = TSQ_DETECT;
      end
      TSQ_DETECT: begin
        if (s_ff.bypass_pend || cmd[`TSQ_CMD_BYPASS_BIT]) begin
          nxt_s.bypass_pend = 1'b0;
          nxt_s.state = TSQ_SEQ;
          nxt_s.start = 1'b1;
          irq_set[`TSQ_IRQ_START_BIT] = 1'b1;
        end else if (trig_evt) begin
          irq_set[`TSQ_IRQ_TRIG_BIT] = 1'b1;
          if (s_ff.delay == '0) begin
            nxt_s.state = TSQ_SEQ;
            nxt_s.start = 1'b1;
            irq_set[`TSQ_IRQ_START_BIT] = 1'b1;
          end else begin
            nxt_s.dcnt = s_ff.delay - DELAY_W'(1);
            nxt_s.state = TSQ_DELAY;
          end
        end
      end
      TSQ_DELAY: begin
        if (s_ff.dcnt == '0) begin
          nxt_s.state = TSQ_SEQ;
          nxt_s.start = 1'b1;
          irq_set[`TSQ_IRQ_START_BIT] = 1'b1;
        end else begin
          nxt_s.dcnt = s_ff.dcnt - DELAY_W'(1);
        end
      end
      TSQ_SEQ: begin
        // single upward condition: the cont flag decides between detection and idle
        if (meas_done_i) begin
          irq_set[`TSQ_IRQ_DONE_BIT] = 1'b1;
          if (s_ff.cont) begin
            nxt_s.state = TSQ_DETECT;
          end else begin
            nxt_s.state = TSQ_IDLE;
            irq_set[`TSQ_IRQ_IDLE_BIT] = 1'b1;
          end
        end
      end
      default: nxt_s.state = TSQ_IDLE;
    endcase

    // abort and reset override the state and the start pulse, even a start decided this cycle (its status bits are still set),
    // so a command that lands with a trigger never launches a measurement
    if (cmd[`TSQ_CMD_ABORT_BIT] || cmd[`TSQ_CMD_RST_BIT]) begin
      nxt_s.state = TSQ_IDLE;
      nxt_s.start = 1'b0;
      nxt_s.bypass_pend = 1'b0;
    end
    if (cmd[`TSQ_CMD_RST_BIT]) begin
      nxt_s.cont = 1'b0;
      nxt_s.delay = DELAY_W'(`TSQ_RST_DELAY);
    end

    // read word is captured in the wait cycle and stands while waitrequest
    // is low; a status read clears only the bits it reported, so an event
    // that arrives during the wait cycle is kept for the next read
    nxt_s.rdata = 32'h0000_0000;
    if (avs_read_i && !s_ff.ack) begin
      nxt_s.rdata = read_word(s_ff, avs_address_i);
    end
    if (rd_ok && avs_address_i == `TSQ_ADDR_IRQ_STAT) begin
      nxt_s.irq_stat = s_ff.irq_stat & ~s_ff.rdata[3:0];
    end
    nxt_s.irq_stat = nxt_s.irq_stat | irq_set; // set wins over clear

    // condition word follows the next state
    nxt_s.opc = cond_of(nxt_s.state);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
      s_ff.state <= TSQ_IDLE;
      s_ff.src <= `TSQ_RST_SRC;
      s_ff.delay <= DELAY_W'(`TSQ_RST_DELAY);
      s_ff.irq_mask <= `TSQ_RST_MASK;
      s_ff.opc <= cond_of(TSQ_IDLE);
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // data outputs come straight from flip-flops
  assign avs_readdata_o = s_ff.rdata;
  assign meas_start_o = s_ff.start;
  assign op_cond_o = s_ff.opc;

  // level interrupt: high while any unmasked sticky status bit is set
  assign irq_o = |(s_ff.irq_stat & s_ff.irq_mask);

endmodule : tsq_top

//--- verif/tsq_top_sva.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module tsq_top_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic meas_done_i,
  input wire logic meas_start_o,
  input wire logic [15:0] op_cond_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a new request sees one wait state, then the answer
  sequence s_new;
    $rose(avs_read_i || avs_write_i);
  endsequence
  sequence s_one_wait;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  // writes may abort a measurement, so they are kept out
  sequence s_meas;
    op_cond_o[4] && !avs_write_i;
  endsequence
  AST_NEW_REQ: assert property (s_new |-> s_one_wait)
    else $error("request not answered after one wait state");
  AST_IDLE_BUS: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest without a request");
  AST_START_ONE: assert property (meas_start_o |=> !meas_start_o)
    else $error("start pulse longer than one cycle");
  AST_START_SEQ: assert property ($rose(op_cond_o[4]) |-> ##[0:1] meas_start_o)
    else $error("no start pulse on entry to measuring");
  AST_HOLD: assert property (s_meas ##0 !meas_done_i |=> op_cond_o[4])
    else $error("measuring left before completion");
  AST_LEAVE: assert property (s_meas ##0 meas_done_i |=> !op_cond_o[4])
    else $error("measuring kept after completion");
  AST_EXCL: assert property (!(op_cond_o[4] && op_cond_o[5]))
    else $error("waiting and measuring together");
  AST_RSVD: assert property (op_cond_o[15:6] == 10'h000 && op_cond_o[3:0] == 4'h0)
    else $error("unused condition bit set");
  AST_RST_IDLE: assert property ($fell(rst_i) |-> op_cond_o == 16'h0000 && !irq_o)
    else $error("not idle after reset");
endmodule : tsq_top_sva
bind tsq_top tsq_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .meas_done_i(meas_done_i),
  .meas_start_o(meas_start_o), .op_cond_o(op_cond_o), .irq_o(irq_o));

//--- verif/tsq_meas_model.sv
`timescale 1ns/1ps
// measurement hardware: done pulse lat_i+1 cycles after the edge that samples start
module tsq_meas_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic meas_start_i,
  input wire logic [2:0] lat_i,
  output logic meas_done_o = 1'b0
);
  int cnt_ff = -1;
  // a restart while busy simply reloads the count
  always @(posedge clk_i) begin
    meas_done_o <= 1'b0;
    if (rst_i) cnt_ff <= -1;
    else if (meas_start_i) cnt_ff <= lat_i;
    else if (cnt_ff == 0) begin
      meas_done_o <= 1'b1;
      cnt_ff <= -1;
    end else if (cnt_ff > 0) cnt_ff <= cnt_ff - 1;
  end
endmodule : tsq_meas_model

//--- verif/tb_tsq_top.sv
`timescale 1ns/1ps
`include "tsq_regs.svh"
module tb_tsq_top import tsq_pkg::*;;
  logic clk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0, ext_trig_i = 0, int_trig_i = 0;
  logic [7:0] avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, q;
  logic avs_waitrequest_o, meas_done_i, meas_start_o, irq_o;
  logic [15:0] op_cond_o;
  logic [2:0] lat = 3'h0;
  logic [31:0] exp_q[$], got_q[$];
  int err_total = 0, total_checks = 0, seed = 22007, starts = 0, d0, dly, s, lat_n;
  always #5 clk_i = ~clk_i;
  tsq_top dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ext_trig_i(ext_trig_i), .int_trig_i(int_trig_i),
    .meas_done_i(meas_done_i), .meas_start_o(meas_start_o), .op_cond_o(op_cond_o), .irq_o(irq_o));
  tsq_meas_model u_meas (.clk_i(clk_i), .rst_i(rst_i), .meas_start_i(meas_start_o),
    .lat_i(lat), .meas_done_o(meas_done_i));
  // count start pulses and vary how slowly the measurement answers
  always @(posedge clk_i) if (meas_start_o === 1'b1) begin
    starts <= starts + 1;
    lat <= $random(seed);
  end
  // ----
  // checking
  // ----
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // read results are compared in arrival order
  always @(posedge clk_i) if (got_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
  task finish_test;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    #300000;
    err_total++;
    finish_test;
  end
  // ----
  // bus master
  // ----
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    if (n >= 64) err_total++;
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
    got_q.push_back(q);
  endtask : rd
  task cmd(input int b);
    bus(1'b1, `TSQ_ADDR_CMD, 32'h0000_0001 << b);
  endtask : cmd
  // a missing start pulse ends the wait and counts as a fault
  task wait_start;
    lat_n = 0;
    while (meas_start_o !== 1'b1 && lat_n < 300) begin
      @(posedge clk_i);
      lat_n++;
    end
    if (lat_n >= 300) err_total++;
  endtask : wait_start
  // ----
  // scenarios
  // ----
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`TSQ_ADDR_OPCOND, 32'h0000_0000);
    rd(`TSQ_ADDR_STATE, 32'h0000_0000);
    rd(`TSQ_ADDR_DELAY, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    bus(1'b1, `TSQ_ADDR_IRQ_MASK, 32'h0000_000F);
    bus(1'b1, `TSQ_ADDR_CTRL, 32'h0000_0000);
    cmd(`TSQ_CMD_ARM_BIT);
    rd(`TSQ_ADDR_STATE, 32'(TSQ_DETECT));
    rd(`TSQ_ADDR_OPCOND, 32'h0000_0020);
    check(op_cond_o, 32'h0000_0020);
    bus(1'b0, `TSQ_ADDR_IRQ_STAT, 32'h0000_0000);
    cmd(`TSQ_CMD_BUS_TRIG_BIT);
    wait_start;
    d0 = lat_n;
    repeat (12) @(posedge clk_i);
    rd(`TSQ_ADDR_OPCOND, 32'h0000_0000);
    check(irq_o, 1'b1);
    rd(`TSQ_ADDR_IRQ_STAT, 32'h0000_000F);
    check(irq_o, 1'b0);
    // programmed delay adds exactly its count; events masked meanwhile
    dly = 5 + ($random(seed) & 15);
    bus(1'b1, `TSQ_ADDR_DELAY, dly);
    bus(1'b1, `TSQ_ADDR_IRQ_MASK, 32'h0000_0000);
    cmd(`TSQ_CMD_ARM_BIT);
    cmd(`TSQ_CMD_BUS_TRIG_BIT);
    wait_start;
    check(lat_n - d0, dly);
    check(op_cond_o, 32'h0000_0010);
    check(irq_o, 1'b0);
    // rearm flag goes on by itself; bypass starts once with no trigger
    bus(1'b1, `TSQ_ADDR_CTRL, 32'h0000_0001);
    // let the running measurement finish so the bypass meets detection
    repeat (12) @(posedge clk_i);
    cmd(`TSQ_CMD_BYPASS_BIT);
    wait_start;
    check(lat_n < d0 + 2, 1'b1);
    s = starts + 1;
    repeat (40) @(posedge clk_i);
    check(starts, s);
    rd(`TSQ_ADDR_OPCOND, 32'h0000_0020);
    // internal level, then external edge held high
    bus(1'b1, `TSQ_ADDR_CTRL, 32'h0000_0011);
    int_trig_i <= 1'b1;
    wait_start;
    int_trig_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    bus(1'b1, `TSQ_ADDR_CTRL, 32'h0000_0021);
    ext_trig_i <= 1'b1;
    wait_start;
    s = starts + 1;
    repeat (60) @(posedge clk_i);
    check(starts, s);
    ext_trig_i <= 1'b0;
    cmd(`TSQ_CMD_RST_BIT);
    repeat (5) @(posedge clk_i);
    rd(`TSQ_ADDR_STATE, 32'h0000_0000);
    rd(`TSQ_ADDR_DELAY, 32'h0000_0000);
    cmd(`TSQ_CMD_ARM_BIT);
    cmd(`TSQ_CMD_ABORT_BIT);
    rd(`TSQ_ADDR_STATE, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    finish_test;
  end
endmodule : tb_tsq_top
